/* File: design/flash_consts.svh */
/*
  Constants for the flash page programming controller and its CPU-side end.
  Assumes inclusion by bare name from design files.
*/
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

// Control register fields
`define CTL_KEY_HI        7
`define CTL_KEY_LO        4
`define CTL_MAP_BIT       3
`define CTL_MODE_HI       2
`define CTL_MODE_LO       1
`define CTL_BUSY_BIT      0
`define CTL_RESET         8'h00
`define KEY_UNLOCK        4'h5
`define KEY_LAUNCH        4'hA

// Space select codes
`define SPACE_CODE        2'h0
`define SPACE_SIG         2'h1
`define SPACE_FUSE        2'h2
`define SPACE_RSV         2'h3

// Eeprom control register fields
`define EE_ERASE_BIT      6
`define EE_ERR_BIT        1
`define EE_RESET          8'h00

// Page layout
`define PAGE_HI           15
`define PAGE_LO           7
`define HALF_BIT          6
`define BYTE_HI           5
`define BUF_LAST          6'h3F
`define PAGE_LAST         7'h7F
`define ERASED_BYTE       8'hFF
`define SIG_WR_TOP_HI     15
`define SIG_WR_TOP_LO     9
`define FUSE_WR_TOP_HI    15
`define FUSE_WR_TOP_LO    7

// Host APB map
`define REG_ADDR          8'h00
`define REG_DATA          8'h04
`define REG_ACTION        8'h08
`define REG_CONFIG        8'h0C
`define REG_STATUS        8'h10
`define ACT_CTRL_WR       3'h1
`define ACT_EEPROM_CONTROL_REG_WR      3'h2
`define ACT_XDATA_WR      3'h3
`define ACT_CODE_RD       3'h4
`define ACT_OTHER_INSTR   3'h5
`define ACT_LAUNCH        3'h6
`define CFG_EXT_EXEC      0
`define CFG_EXT_RAM       1
`define CFG_IRQ_EN        2

`endif

/* File: design/flash_pkg.sv */
/*
  Types for the flash page programming controller and its CPU-side end.
  Assumes flash_consts.svh is on the include path.
*/
package flash_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ERASE   = 2'b01,
    ST_PROG_RD = 2'b10,
    ST_PROG_WR = 2'b11
  } prog_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_EE   = 2'b01,
    H_K5   = 2'b10,
    H_KA   = 2'b11
  } host_state_t;

  typedef struct packed {
    prog_state_t      st;
    logic             map;
    logic [1:0]       mode;
    logic             armed;
    logic             busy;
    logic             ext;
    logic             ae;
    logic             err;
    logic [1:0]       op_mode;
    logic [8:0]       page;
    logic             half;
    logic [6:0]       idx;
    logic [63:0]      loaded;
    logic [63:0][7:0] pbuf;
    logic [2:0]       bo_sync;
    logic             bo_lvl;
    logic [1:0]       arr_space;
    logic [15:0]      arr_addr;
    logic [7:0]       arr_wdata;
    logic             arr_we;
    logic             rd_pend;
    logic [7:0]       code_q;
    logic             code_v;
    logic             ram_wr;
    logic             ram_ext;
    logic [15:0]      ram_addr;
    logic [7:0]       ram_data;
  } dev_regs_t;

  typedef struct packed {
    host_state_t st;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [2:0]  cfg;
    logic        erase_pend;
    logic        ae_now;
    logic [7:0]  code_last;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq_en;
    logic        ctrl_wr;
    logic        eeprom_control_reg_wr;
    logic        xdata_wr;
    logic        code_rd;
    logic        other_instr;
    logic [7:0]  wdata;
    logic [15:0] waddr;
  } host_regs_t;

endpackage

/* File: design/flash_if.sv */
/*
  Link between the CPU-side end and the flash programming controller.
  Assumes both ends share clock_in and resetn_in.
*/
`timescale 1ns/100ps
interface flash_if;
  logic        ctrl_wr;
  logic [7:0]  ctrl_wdata;
  logic        eeprom_control_reg_wr;
  logic [7:0]  eeprom_control_reg_wdata;
  logic        xdata_wr;
  logic [15:0] xdata_addr;
  logic [7:0]  xdata_wdata;
  logic        code_rd;
  logic [15:0] code_addr;
  logic        other_instr;
  logic        ext_exec;
  logic        ext_ram_sel;
  logic [7:0]  ctrl_rdata;
  logic [7:0]  eeprom_control_reg_rdata;
  logic [7:0]  code_rdata;
  logic        code_valid;
  logic        cpu_idle;

  modport dev (
    input  ctrl_wr, ctrl_wdata, eeprom_control_reg_wr, eeprom_control_reg_wdata, xdata_wr, xdata_addr,
    input  xdata_wdata, code_rd, code_addr, other_instr, ext_exec, ext_ram_sel,
    output ctrl_rdata, eeprom_control_reg_rdata, code_rdata, code_valid, cpu_idle
  );

  modport host (
    output ctrl_wr, ctrl_wdata, eeprom_control_reg_wr, eeprom_control_reg_wdata, xdata_wr, xdata_addr,
    output xdata_wdata, code_rd, code_addr, other_instr, ext_exec, ext_ram_sel,
    input  ctrl_rdata, eeprom_control_reg_rdata, code_rdata, code_valid, cpu_idle
  );
endinterface

/* File: design/flash_device.sv */
/*
  Flash page programming controller: control and eeprom control registers,
  64-byte half-page buffer, keyed launch, erase and program sequencer.
  Assumes an external flash array with combinational read data for the
  address it is given, and a brown-out level from outside the clock domain.
*/
// The implementer's own choices: the address map and the APB slave port.
// Overview of operation
// - Code space readable only, no direct write
// - Map bit sends data writes to buffer
// - Bits 6..0 pick byte, 15..7 page
// - Map bit overrides external RAM select
// - Space select maps code, signature, fuses
// - Key 5 then A launches programming
// - Key 5 idle; A in mode 0 writes code
// - A writes signature or fuses; reserved ignored
// - Intervening instruction aborts the key pair
// - Interrupts stay disabled while programming, except in its first busy cycle
// - Busy high during programming, cleared after
// - Brown-out during programming sets error flag
// - Buffer is 64 bytes, half a page
// - Loaded location ignores reloads until cleared
// - Buffer cleared after every erase or write
// - No auto-erase: unloaded bytes stay unchanged
// - Auto-erase wipes whole page to FFH first
// - Auto-erase write needs second plain write
// - Internal launch idles CPU; external polls busy
// - Last loaded address gives target page
// - Launch pairs 50/A0, 52/A2, 54/A4
// - Control value 00H maps user code
// - Flash write only clears bits
`timescale 1ns/100ps
`include "flash_consts.svh"
module flash_device (
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  flash_if.dev             cpu,
  input  wire logic        brownout_in,
  input  wire logic [7:0]  arr_rdata_in,
  output logic      [1:0]  arr_space_out,
  output logic      [15:0] arr_addr_out,
  output logic      [7:0]  arr_wdata_out,
  output logic             arr_we_out,
  output logic             ram_wr_out,
  output logic             ram_ext_out,
  output logic      [15:0] ram_addr_out,
  output logic      [7:0]  ram_data_out
);
  import flash_pkg::*;

  dev_regs_t r_q;
  dev_regs_t r_d;
  logic      wr_ok;
  logic [5:0] bidx;
  logic [3:0] key;
  logic [1:0] wmode;

  // Target address may be written in the current operation space
  function automatic logic writable(input logic [1:0] sp, input logic [15:0] a);
    writable = (sp == `SPACE_CODE)
             | ((sp == `SPACE_SIG)  & (a[`SIG_WR_TOP_HI:`SIG_WR_TOP_LO] == '0))
             | ((sp == `SPACE_FUSE) & (a[`FUSE_WR_TOP_HI:`FUSE_WR_TOP_LO] == '0));
  endfunction

  always_comb begin
    r_d   = r_q;
    bidx  = r_q.idx[`BYTE_HI:0];
    key   = cpu.ctrl_wdata[`CTL_KEY_HI:`CTL_KEY_LO];
    wmode = cpu.ctrl_wdata[`CTL_MODE_HI:`CTL_MODE_LO];
    wr_ok = 1'b0;
    r_d.arr_we = 1'b0;
    r_d.ram_wr = 1'b0;
    r_d.code_v = 1'b0;

    // Brown-out level through three flops, taken when the last two agree
    r_d.bo_sync = {r_q.bo_sync[1:0], brownout_in};
    if (r_q.bo_sync[2] == r_q.bo_sync[1]) begin
      r_d.bo_lvl = r_q.bo_sync[2];
    end

    if (cpu.other_instr) begin
      r_d.armed = 1'b0;
    end

    if (cpu.eeprom_control_reg_wr) begin
      r_d.ae  = cpu.eeprom_control_reg_wdata[`EE_ERASE_BIT];
      r_d.err = r_q.err & cpu.eeprom_control_reg_wdata[`EE_ERR_BIT];
    end

    if (cpu.ctrl_wr) begin
      r_d.map   = cpu.ctrl_wdata[`CTL_MAP_BIT];
      r_d.mode  = wmode;
      r_d.armed = 1'b0;
      if (key == `KEY_UNLOCK) begin
        r_d.armed = 1'b1;
      end else if ((key == `KEY_LAUNCH) && r_q.armed && !r_q.busy &&
                   (wmode != `SPACE_RSV)) begin
        r_d.busy    = 1'b1;
        r_d.op_mode = wmode;
        r_d.ext     = cpu.ext_exec;
        r_d.idx     = '0;
        r_d.st      = r_q.ae ? ST_ERASE : ST_PROG_RD;
      end
    end

    // Data writes: buffer while mapped, else ordinary data memory
    if (cpu.xdata_wr) begin
      if (r_q.map) begin
        if (!r_q.busy) begin
          if (!r_q.loaded[cpu.xdata_addr[`BYTE_HI:0]]) begin
            r_d.pbuf[cpu.xdata_addr[`BYTE_HI:0]]   = cpu.xdata_wdata;
            r_d.loaded[cpu.xdata_addr[`BYTE_HI:0]] = 1'b1;
          end
          r_d.page = cpu.xdata_addr[`PAGE_HI:`PAGE_LO];
          r_d.half = cpu.xdata_addr[`HALF_BIT];
        end
      end else begin
        r_d.ram_wr   = 1'b1;
        r_d.ram_ext  = cpu.ext_ram_sel;
        r_d.ram_addr = cpu.xdata_addr;
        r_d.ram_data = cpu.xdata_wdata;
      end
    end

    // Code reads go to the mapped space, never while programming
    if (r_q.rd_pend) begin
      r_d.rd_pend = 1'b0;
      r_d.code_v  = 1'b1;
      r_d.code_q  = (r_q.arr_space == `SPACE_RSV) ? `ERASED_BYTE : arr_rdata_in;
    end
    if (cpu.code_rd && !r_q.busy) begin
      r_d.arr_space = r_q.mode;
      r_d.arr_addr  = cpu.code_addr;
      r_d.rd_pend   = 1'b1;
    end

    unique case (r_q.st)
      ST_IDLE: begin
      end
      ST_ERASE: begin
        r_d.arr_space = r_q.op_mode;
        r_d.arr_addr  = {r_q.page, r_q.idx};
        r_d.arr_wdata = `ERASED_BYTE;
        r_d.arr_we    = writable(r_q.op_mode, {r_q.page, r_q.idx});
        r_d.idx       = r_q.idx + 7'h01;
        if (r_q.idx == `PAGE_LAST) begin
          r_d.idx = '0;
          r_d.st  = ST_PROG_RD;
        end
      end
      ST_PROG_RD: begin
        r_d.arr_space = r_q.op_mode;
        r_d.arr_addr  = {r_q.page, r_q.half, bidx};
        if (r_q.loaded[bidx]) begin
          r_d.st = ST_PROG_WR;
        end else if (bidx == `BUF_LAST) begin
          r_d.st     = ST_IDLE;
          r_d.busy   = 1'b0;
          r_d.loaded = '0;
        end else begin
          r_d.idx = r_q.idx + 7'h01;
        end
      end
      ST_PROG_WR: begin
        wr_ok         = writable(r_q.op_mode, r_q.arr_addr);
        r_d.arr_wdata = arr_rdata_in & r_q.pbuf[bidx];
        r_d.arr_we    = wr_ok;
        r_d.idx       = r_q.idx + 7'h01;
        r_d.st        = ST_PROG_RD;
        if (bidx == `BUF_LAST) begin
          r_d.st     = ST_IDLE;
          r_d.busy   = 1'b0;
          r_d.loaded = '0;
        end
      end
    endcase

    // Brown-out ends the operation and flags it; the set wins over a clear
    if (r_q.bo_lvl && r_q.busy) begin
      r_d.st     = ST_IDLE;
      r_d.busy   = 1'b0;
      r_d.arr_we = 1'b0;
      r_d.loaded = '0;
      r_d.err    = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      r_q         <= '0;
      r_q.st      <= ST_IDLE;
      r_q.bo_sync <= 3'b000;
    end else begin
      r_q <= r_d;
    end
  end

  assign cpu.ctrl_rdata  = {4'h0, r_q.map, r_q.mode, r_q.busy};
  assign cpu.eeprom_control_reg_rdata = {1'b0, r_q.ae, 4'h0, r_q.err, 1'b0};
  assign cpu.code_rdata  = r_q.code_q;
  assign cpu.code_valid  = r_q.code_v;
  assign cpu.cpu_idle    = r_q.busy & ~r_q.ext;
  assign arr_space_out   = r_q.arr_space;
  assign arr_addr_out    = r_q.arr_addr;
  assign arr_wdata_out   = r_q.arr_wdata;
  assign arr_we_out      = r_q.arr_we;
  assign ram_wr_out      = r_q.ram_wr;
  assign ram_ext_out     = r_q.ram_ext;
  assign ram_addr_out    = r_q.ram_addr;
  assign ram_data_out    = r_q.ram_data;
endmodule

/* File: design/flash_host.sv */
/*
  CPU-side end: APB slave registers turn software orders into control,
  buffer load, code read and launch accesses toward the controller.
  Assumes the controller answers code reads with a one-cycle valid pulse.
*/
`timescale 1ns/100ps
`include "flash_consts.svh"
module flash_host (
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  flash_if.host            dev,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             global_irq_enable_out
);
  import flash_pkg::*;

  host_regs_t r_q;
  host_regs_t r_d;
  logic       setup;
  logic       wr_take;
  logic       mapped;

  always_comb begin
    r_d     = r_q;
    setup   = psel_in & ~penable_in;
    wr_take = psel_in & penable_in & pwrite_in;
    mapped  = (paddr_in == `REG_ADDR) | (paddr_in == `REG_DATA) |
              (paddr_in == `REG_ACTION) | (paddr_in == `REG_CONFIG) |
              (paddr_in == `REG_STATUS);
    r_d.ctrl_wr     = 1'b0;
    r_d.eeprom_control_reg_wr    = 1'b0;
    r_d.xdata_wr    = 1'b0;
    r_d.code_rd     = 1'b0;
    r_d.other_instr = 1'b0;

    if (dev.code_valid) begin
      r_d.code_last = dev.code_rdata;
    end

    // Read data and error prepared in setup, shown in the access phase
    if (setup) begin
      r_d.pslverr = ~mapped;
      r_d.prdata  = '0;
      unique case (paddr_in)
        `REG_ADDR:   r_d.prdata = {16'h0000, r_q.addr};
        `REG_DATA:   r_d.prdata = {24'h000000, r_q.data};
        `REG_CONFIG: r_d.prdata = {29'h00000000, r_q.cfg};
        `REG_STATUS: r_d.prdata = {6'h00, (r_q.st != H_IDLE), dev.cpu_idle,
                                   r_q.code_last, dev.eeprom_control_reg_rdata, dev.ctrl_rdata};
        default:     r_d.prdata = '0;
      endcase
    end

    if (wr_take) begin
      if (paddr_in == `REG_ADDR) begin
        r_d.addr = pwdata_in[15:0];
      end
      if (paddr_in == `REG_DATA) begin
        r_d.data = pwdata_in[7:0];
      end
      if (paddr_in == `REG_CONFIG) begin
        r_d.cfg = pwdata_in[2:0];
      end
      if ((paddr_in == `REG_ACTION) && (r_q.st == H_IDLE)) begin
        r_d.wdata = r_q.data;
        r_d.waddr = r_q.addr;
        unique case (pwdata_in[2:0])
          `ACT_CTRL_WR:     r_d.ctrl_wr = 1'b1;
          `ACT_EEPROM_CONTROL_REG_WR:    r_d.eeprom_control_reg_wr = 1'b1;
          `ACT_XDATA_WR:    r_d.xdata_wr = 1'b1;
          `ACT_CODE_RD:     r_d.code_rd = 1'b1;
          `ACT_OTHER_INSTR: r_d.other_instr = 1'b1;
          `ACT_LAUNCH: begin
            r_d.ae_now = r_q.data[`EE_ERASE_BIT] & ~r_q.erase_pend;
            r_d.st     = H_EE;
          end
          default: begin
          end
        endcase
      end
    end

    // Launch: eeprom control, then the key pair back to back
    unique case (r_q.st)
      H_IDLE: begin
      end
      H_EE: begin
        r_d.eeprom_control_reg_wr   = 1'b1;
        r_d.wdata      = {1'b0, r_q.ae_now, 6'h02};
        r_d.erase_pend = r_q.ae_now;
        r_d.st         = H_K5;
      end
      H_K5: begin
        r_d.ctrl_wr = 1'b1;
        r_d.wdata   = {`KEY_UNLOCK, 1'b0, r_q.data[1:0], 1'b0};
        r_d.st      = H_KA;
      end
      H_KA: begin
        r_d.ctrl_wr = 1'b1;
        r_d.wdata   = {`KEY_LAUNCH, 1'b0, r_q.data[1:0], 1'b0};
        r_d.st      = H_IDLE;
      end
    endcase

    // Interrupts held off across launch and from the second busy cycle on
    r_d.irq_en = r_q.cfg[`CFG_IRQ_EN] & (r_d.st == H_IDLE) &
                 ~dev.ctrl_rdata[`CTL_BUSY_BIT] & (r_q.st == H_IDLE);
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      r_q    <= '0;
      r_q.st <= H_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata_out            = r_q.prdata;
  assign pready_out            = 1'b1;
  assign pslverr_out           = r_q.pslverr & psel_in & penable_in;
  assign global_irq_enable_out = r_q.irq_en;
  assign dev.ctrl_wr           = r_q.ctrl_wr;
  assign dev.ctrl_wdata        = r_q.wdata;
  assign dev.eeprom_control_reg_wr          = r_q.eeprom_control_reg_wr;
  assign dev.eeprom_control_reg_wdata       = r_q.wdata;
  assign dev.xdata_wr          = r_q.xdata_wr;
  assign dev.xdata_addr        = r_q.waddr;
  assign dev.xdata_wdata       = r_q.wdata;
  assign dev.code_rd           = r_q.code_rd;
  assign dev.code_addr         = r_q.waddr;
  assign dev.other_instr       = r_q.other_instr;
  assign dev.ext_exec          = r_q.cfg[`CFG_EXT_EXEC];
  assign dev.ext_ram_sel       = r_q.cfg[`CFG_EXT_RAM];
endmodule

/* File: bench/flash_page_program_control_assertions.sv */
/*
  Checker for the link between the CPU-side end and the flash controller.
  Assumes it sees the flash_if signals and the shared clock and reset.
*/
`timescale 1ns/100ps
module flash_page_program_control_assertions (
  input wire logic       clock_in,
  input wire logic       resetn_in,
  input wire logic       ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic       code_rd,
  input wire logic       other_instr,
  input wire logic       ext_exec,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [7:0] eeprom_control_reg_rdata,
  input wire logic       code_valid,
  input wire logic       cpu_idle
);
  logic       busy;
  logic       key5;
  logic       keya;
  logic [9:0] busy_cnt_q;
  logic       armed_q;
  assign busy = ctrl_rdata[0];
  assign key5 = ctrl_wr && ctrl_wdata[7:4] == 4'h5 && !busy;
  assign keya = ctrl_wr && ctrl_wdata[7:4] == 4'hA && !busy;
  // Cycles spent busy
  always_ff @(posedge clock_in) begin
    if (!resetn_in || !busy)
      busy_cnt_q <= 10'h000;
    else
      busy_cnt_q <= busy_cnt_q + 10'h001;
  end
  // Key armed by a 5 write, lost on any other instruction
  always_ff @(posedge clock_in) begin
    if (!resetn_in)
      armed_q <= 1'b0;
    else if (ctrl_wr)
      armed_q <= ctrl_wdata[7:4] == 4'h5;
    else if (other_instr)
      armed_q <= 1'b0;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  chk_key_launch: assert property (
    $past(key5) && keya && ctrl_wdata[2:1] != 2'h3 && !other_instr |=> busy)
    else $error("launch pair did not start programming");
  chk_key_reserved: assert property (keya && ctrl_wdata[2:1] == 2'h3 |=> !busy)
    else $error("reserved space launch started programming");
  chk_key_abort: assert property (keya && !armed_q |=> !busy)
    else $error("launch after intervening instruction started");
  chk_key_idle: assert property (
    ctrl_wr && ctrl_wdata[7:4] != 4'hA && !busy |=> !busy)
    else $error("control write without launch key set busy");
  chk_read_answer: assert property (code_rd && !busy |-> ##2 code_valid)
    else $error("code read not answered in two cycles");
  chk_read_cause: assert property (code_valid |-> $past(code_rd, 2))
    else $error("code data valid without a read");
  chk_read_busy: assert property (code_rd && busy |-> ##2 !code_valid)
    else $error("code read answered while busy");
  chk_err_cause: assert property ($rose(eeprom_control_reg_rdata[1]) |-> $past(busy))
    else $error("error flag set outside programming");
  chk_idle_mode: assert property ($rose(busy) |-> cpu_idle == !ext_exec)
    else $error("cpu idle does not follow execution place");
  chk_idle_busy: assert property (cpu_idle |-> busy)
    else $error("cpu idle while not busy");
  chk_busy_bound: assert property (busy_cnt_q < 10'h12C)
    else $error("programming never completed");
  chk_reset_map: assert property ($rose(resetn_in) |-> ctrl_rdata == 8'h00)
    else $error("control register not cleared by reset");
endmodule

/* File: bench/flash_page_program_control_test.sv */
/*
  Testbench: APB master on the CPU-side end, flash array model on the
  controller. Assumes the design files and flash_consts.svh are visible.
*/
`timescale 1ns/100ps
`include "flash_consts.svh"
module flash_page_program_control_test;
  import flash_pkg::*;
  typedef struct packed {
    logic [1:0]  m;
    logic        ae;
    logic [15:0] la;
    logic [7:0]  d;
    logic [15:0] ra;
    logic [7:0]  e;
  } row_t;
  logic        clock_in, resetn_in, brownout_in, psel_in, penable_in, pwrite_in;
  logic        arr_we_out, ram_wr_out, ram_ext_out, pready_out, pslverr_out, irq_out;
  logic        last_err, b0, b1;
  logic [1:0]  arr_space_out;
  logic [7:0]  arr_rdata_in, arr_wdata_out, ram_data_out, paddr_in, v;
  logic [15:0] arr_addr_out, ram_addr_out;
  logic [24:0] ram_last;
  logic [31:0] pwdata_in, prdata_out, s;
  logic [7:0]  mem [0:16383];
  int          n_errors, n_checks, ram_cnt;
  row_t        rows [9] = '{
    '{2'h0, 1'h0, 16'h1234, 8'hA5, 16'h1234, 8'hA5},
    '{2'h0, 1'h0, 16'h1234, 8'h5A, 16'h1234, 8'h00},
    '{2'h0, 1'h0, 16'h1250, 8'h0F, 16'h1250, 8'h0F},
    '{2'h0, 1'h1, 16'h1234, 8'hC3, 16'h1250, 8'hFF},
    '{2'h0, 1'h1, 16'h1236, 8'h11, 16'h1234, 8'hC3},
    '{2'h1, 1'h0, 16'h0010, 8'h3C, 16'h0010, 8'h3C},
    '{2'h2, 1'h0, 16'h0020, 8'h0F, 16'h0020, 8'h0F},
    '{2'h2, 1'h0, 16'h0090, 8'h00, 16'h0090, 8'hFF},
    '{2'h0, 1'h0, 16'h3000, 8'h77, 16'h0010, 8'hFF}};
  flash_if link ();
  flash_device i_flash_device (.clock_in(clock_in), .resetn_in(resetn_in), .cpu(link),
    .brownout_in(brownout_in), .arr_rdata_in(arr_rdata_in), .arr_space_out(arr_space_out),
    .arr_addr_out(arr_addr_out), .arr_wdata_out(arr_wdata_out), .arr_we_out(arr_we_out),
    .ram_wr_out(ram_wr_out), .ram_ext_out(ram_ext_out), .ram_addr_out(ram_addr_out),
    .ram_data_out(ram_data_out));
  flash_host i_flash_host (.clock_in(clock_in), .resetn_in(resetn_in), .dev(link),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .global_irq_enable_out(irq_out));
  flash_page_program_control_assertions u_chk (.clock_in(clock_in), .resetn_in(resetn_in),
    .ctrl_wr(link.ctrl_wr), .ctrl_wdata(link.ctrl_wdata), .code_rd(link.code_rd),
    .other_instr(link.other_instr), .ext_exec(link.ext_exec), .ctrl_rdata(link.ctrl_rdata),
    .eeprom_control_reg_rdata(link.eeprom_control_reg_rdata), .code_valid(link.code_valid), .cpu_idle(link.cpu_idle));
  // Flash array and data memory models
  assign arr_rdata_in = mem[{arr_space_out, arr_addr_out[11:0]}];
  always @(posedge clock_in) begin
    if (arr_we_out === 1'b1)
      mem[{arr_space_out, arr_addr_out[11:0]}] <= arr_wdata_out;
    if (ram_wr_out === 1'b1) begin
      ram_cnt <= ram_cnt + 1;
      ram_last <= {ram_ext_out, ram_addr_out, ram_data_out};
    end
  end
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task tally_and_finish;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      tally_and_finish();
    end
    r = prdata_out;
    last_err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task ctl(input logic [7:0] d);
    wr(`REG_DATA, {24'h0, d});
    wr(`REG_ACTION, {29'h0, `ACT_CTRL_WR});
  endtask
  task load(input logic [15:0] a, input logic [7:0] d);
    ctl(8'h08);
    wr(`REG_ADDR, {16'h0, a});
    wr(`REG_DATA, {24'h0, d});
    wr(`REG_ACTION, {29'h0, `ACT_XDATA_WR});
  endtask
  task cread(input logic [1:0] m, input logic [15:0] a, output logic [7:0] r);
    ctl({5'h00, m, 1'b0});
    wr(`REG_ADDR, {16'h0, a});
    wr(`REG_ACTION, {29'h0, `ACT_CODE_RD});
    repeat (3) @(posedge clock_in);
    apb(1'b0, `REG_STATUS, 32'h0, s);
    r = s[23:16];
  endtask
  task launch(input logic [1:0] m, input logic ae, output logic seen, output logic idl);
    int n;
    wr(`REG_DATA, {25'h0, ae, 4'h0, m});
    wr(`REG_ACTION, {29'h0, `ACT_LAUNCH});
    seen = 1'b0;
    idl = 1'b0;
    for (n = 0; n < 300; n++) begin
      apb(1'b0, `REG_STATUS, 32'h0, s);
      if (s[0] === 1'b1)
        seen = 1'b1;
      if (s[24] === 1'b1)
        idl = 1'b1;
      if ((seen && s[0] === 1'b0) || (!seen && n > 8))
        break;
    end
    if (n >= 300) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  initial begin
    repeat (90000) @(posedge clock_in);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    {resetn_in, brownout_in, psel_in, penable_in, pwrite_in} = 5'h00;
    {paddr_in, pwdata_in, n_errors, n_checks, ram_cnt, ram_last} = '0;
    for (int i = 0; i < 16384; i++)
      mem[i] = 8'hFF;
    mem[14'h3010] = 8'h00;
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
    apb(1'b0, `REG_STATUS, 32'h0, s);
    chk8("ctrl reset", 8'h00, s[7:0]);
    chk8("eeprom_control_reg reset", 8'h00, s[15:8]);
    apb(1'b0, 8'h40, 32'h0, s);
    chk1("unmapped", 1'b1, last_err);
    foreach (rows[i]) begin
      load(rows[i].la, rows[i].d);
      launch(rows[i].m, rows[i].ae, b0, b1);
      chk1("row busy", 1'b1, b0);
      cread(rows[i].m, rows[i].ra, v);
      chk8("row read", rows[i].e, v);
    end
    load(16'h1300, 8'hF0);
    load(16'h1300, 8'h0F);
    launch(2'h0, 1'b0, b0, b1);
    chk1("cpu idle internal", 1'b1, b1);
    cread(2'h0, 16'h1300, v);
    chk8("reload", 8'hF0, v);
    load(16'h1400, 8'h12);
    load(16'h1501, 8'h34);
    wr(`REG_CONFIG, 32'h1);
    launch(2'h0, 1'b0, b0, b1);
    chk1("cpu idle external", 1'b0, b1);
    cread(2'h0, 16'h1500, v);
    chk8("last page", 8'h12, v);
    cread(2'h0, 16'h1400, v);
    chk8("first page", 8'hFF, v);
    ctl(8'h50);
    wr(`REG_ACTION, {29'h0, `ACT_OTHER_INSTR});
    ctl(8'hA0);
    ctl(8'h01);
    apb(1'b0, `REG_STATUS, 32'h0, s);
    chk1("broken key", 1'b0, s[0]);
    load(16'h16BF, 8'h00);
    fork
      launch(2'h0, 1'b0, b0, b1);
      begin
        repeat (14) @(posedge clock_in);
        brownout_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        brownout_in <= 1'b0;
      end
    join
    apb(1'b0, `REG_STATUS, 32'h0, s);
    chk1("error flag", 1'b1, s[9]);
    cread(2'h0, 16'h16BF, v);
    chk8("aborted byte", 8'hFF, v);
    wr(`REG_CONFIG, 32'h2);
    for (int k = 0; k < 2; k++) begin
      ctl(k == 0 ? 8'h00 : 8'h08);
      wr(`REG_ADDR, 32'h42);
      wr(`REG_DATA, 32'h99);
      wr(`REG_ACTION, {29'h0, `ACT_XDATA_WR});
      repeat (3) @(posedge clock_in);
      chk8("ram writes", 8'h01, ram_cnt[7:0]);
    end
    chk8("ram data", 8'h99, ram_last[7:0]);
    chk1("ram ext", 1'b1, ram_last[24]);
    chk8("ram addr", 8'h42, ram_last[15:8]);
    launch(2'h3, 1'b0, b0, b1);
    chk1("reserved busy", 1'b0, b0);
    cread(2'h3, 16'h0010, v);
    chk8("reserved read", 8'hFF, v);
    wr(`REG_CONFIG, 32'h5);
    load(16'h1700, 8'h3C);
    wr(`REG_DATA, 32'h0);
    wr(`REG_ACTION, {29'h0, `ACT_LAUNCH});
    wr(`REG_ADDR, 32'h1700);
    wr(`REG_ACTION, {29'h0, `ACT_CODE_RD});
    chk1("irq busy", 1'b0, irq_out);
    repeat (3) @(posedge clock_in);
    apb(1'b0, `REG_STATUS, 32'h0, s);
    chk1("busy read", 1'b1, s[0]);
    chk8("read while busy", 8'hFF, s[23:16]);
    repeat (200) @(posedge clock_in);
    chk1("irq idle", 1'b1, irq_out);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    apb(1'b0, `REG_STATUS, 32'h0, s);
    chk8("ctrl rerun", 8'h00, s[7:0]);
    chk8("eeprom_control_reg rerun", 8'h00, s[15:8]);
    tally_and_finish();
  end
endmodule
